// File: verilog/acs_pkg.sv
// Purpose: Shared constants and types for the converter sequence control.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes: Contract
// Contract
// - Each sample resolves to 8 bits by successive approximation in eight decisions.
// - Mode bit 0 picks conversion length: 0 is 34, 1 is 67 instruction cycles.
// - Mode bits 1 to 3 select the analog input channel converted.
// - Mode register is 4-bit, write-only, all bits reset to 0.
// - Result is 8-bit read-only, read as low and high digits separately.
// - Reset leaves the result register unchanged.
// - The result holds after completion until the next conversion begins.
// - Writing 1 to the start flag begins a conversion with selected channel, length.
// - On finish the result is loaded, then the start flag clears; here both change on the same clock edge, at the end of the store state.
// - Current-off flag at 1 disconnects ladder current in active and standby.
// - Converter does not operate in stop, watch or subactive modes.
// - In those low-power modes ladder current is cut regardless of the flag.
`default_nettype none
package acs_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 4;
  localparam int          RES_W          = 8;
  localparam int          CH_W           = 3;
  localparam int          EV_W           = 2;
  localparam int          CNT_W          = 7;
  // Register map
  localparam logic [7:0]  MODE_OFS       = 8'h16;
  localparam logic [7:0]  RES_LO_OFS     = 8'h17;
  localparam logic [7:0]  RES_HI_OFS     = 8'h18;
  localparam logic [7:0]  START_OFS      = 8'h20;
  localparam logic [7:0]  CUROFF_OFS     = 8'h21;
  localparam logic [7:0]  IRQ_STAT_OFS   = 8'h30;
  localparam logic [7:0]  IRQ_MASK_OFS   = 8'h31;
  // Field layout
  localparam int          MODE_LEN_BIT   = 0;
  localparam int          MODE_CH_LSB    = 1;
  localparam int          FLAG_BIT       = 2;
  localparam int          EV_DONE        = 0;
  localparam int          EV_COLLIDE     = 1;
  // Reset values
  localparam logic [3:0]  MODE_RST       = 4'h0;
  localparam logic [1:0]  IRQ_RST        = 2'h0;
  localparam logic [7:0]  SAR_SEED       = 8'h80;
  // Timing
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          INSTR_CYCLE_NS = 200;
  localparam int          INSTR_DIV      = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  CONV_SHORT     = 7'h22;
  localparam logic [6:0]  CONV_LONG      = 7'h43;
  localparam logic [6:0]  APPROX_LEAD    = 7'h09;
  localparam logic [6:0]  LAST_LEAD      = 7'h01;
  localparam logic [6:0]  CNT_STEP       = 7'h01;

  typedef enum logic [1:0] {
    ACS_IDLE   = 2'b00,
    ACS_SAMPLE = 2'b01,
    ACS_APPROX = 2'b10,
    ACS_STORE  = 2'b11
  } acs_state_e;
endpackage
`default_nettype wire

// File: verilog/acs_sar_if.sv
// Purpose: Carrier between sequencer and approximation register.
// Assumes: Same clock on both ends.
// Notes: Trial code is a flop output of the register side.
`timescale 1ns/10ps
`default_nettype none
interface acs_sar_if;
  logic       clear;
  logic       step;
  logic       cmp;
  logic [7:0] code;
  modport seq (output clear, output step, output cmp, input code);
  modport sar (input clear, input step, input cmp, output code);
endinterface
`default_nettype wire

// File: verilog/acs_tick_div.sv
// Purpose: Instruction-cycle enable pulse from the system clock.
// Assumes: Enable low halts the count, as the oscillator would.
// Notes: Pulse is combinational so a halt drops it at once.
`timescale 1ns/10ps
`default_nettype none
module acs_tick_div
  import acs_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      tick_o
);
  logic [2:0] div_reg;
  wire        at_end = (div_reg == 3'(INSTR_DIV - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || (en_i && at_end)) begin
      div_reg <= 3'h0;
    end else if (en_i) begin
      div_reg <= div_reg + 3'h1;
    end
  end

  assign tick_o = en_i && at_end;
endmodule // acs_tick_div
`default_nettype wire

// File: verilog/acs_sar_reg.sv
// Purpose: Successive approximation register, one decision per step.
// Assumes: Comparator high means input at or above the trial code.
// Notes: One-hot pointer marks the bit under trial.
`timescale 1ns/10ps
`default_nettype none
module acs_sar_reg
  import acs_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  acs_sar_if.sar    sar
);
  logic [RES_W-1:0] code_reg;
  logic [RES_W-1:0] code_next;
  logic [RES_W-1:0] ptr_reg;
  wire  [RES_W-1:0] ptr_dn = ptr_reg >> 1;

  genvar i;
  for (i = 0; i < RES_W; i++) begin : g_bit
    // Keep or drop the trial bit, raise the next one down
    assign code_next[i] = sar.clear ? SAR_SEED[i] :
                          !sar.step ? code_reg[i] :
                          ptr_reg[i] ? (code_reg[i] & sar.cmp) :
                          ptr_dn[i] ? 1'b1 : code_reg[i];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      code_reg <= SAR_SEED;
      ptr_reg  <= SAR_SEED;
    end else begin
      code_reg <= code_next;
      if (sar.clear) begin
        ptr_reg <= SAR_SEED;
      end else if (sar.step) begin
        ptr_reg <= ptr_dn;
      end
    end
  end

  assign sar.code = code_reg;
endmodule // acs_sar_reg
`default_nettype wire

// File: verilog/acs_seq_ctrl.sv
// Purpose: Converter sequence control with register port and interrupt.
// Assumes: Comparator arrives from analog, so it is synchronised.
// Notes: Low-power input comes from on-chip logic on the same clock.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module acs_seq_ctrl
  import acs_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              cmp_i,
  input  wire logic              lowpower_i,
  output logic      [CH_W-1:0]   chan_sel_o,
  output logic      [RES_W-1:0]  dac_code_o,
  output logic                   sample_o,
  output logic                   ladder_en_o,
  output logic                   busy_o,
  output logic                   irq_o
);
  acs_sar_if sar_bus();

  // Instruction cycle enable, halted with the oscillator
  logic tick;
  acs_tick_div u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .en_i      (!lowpower_i),
    .tick_o    (tick)
  );

  acs_sar_reg u_sar (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .sar       (sar_bus.sar)
  );

  // Register state
  logic [3:0]       mode_reg;
  logic             start_flag_reg;
  logic             curoff_reg;
  logic [EV_W-1:0]  stat_reg;
  logic [EV_W-1:0]  mask_reg;
  logic [RES_W-1:0] result_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic             irq_reg;
  logic             ladder_reg;

  // Sequencer state
  acs_state_e       state_reg;
  acs_state_e       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] len_reg;
  logic [CH_W-1:0]  chan_reg;
  logic             sample_reg;

  // Comparator synchroniser, first stage read only by the second
  logic             cmp_meta_reg;
  logic             cmp_sync_reg;

  // Address decode
  wire hit_mode   = (addr_i == MODE_OFS);
  wire hit_res_lo = (addr_i == RES_LO_OFS);
  wire hit_res_hi = (addr_i == RES_HI_OFS);
  wire hit_start  = (addr_i == START_OFS);
  wire hit_curoff = (addr_i == CUROFF_OFS);
  wire hit_stat   = (addr_i == IRQ_STAT_OFS);
  wire hit_mask   = (addr_i == IRQ_MASK_OFS);

  wire wr_mode    = wr_i && hit_mode;
  wire wr_start   = wr_i && hit_start;
  wire wr_curoff  = wr_i && hit_curoff;
  wire wr_stat    = wr_i && hit_stat;
  wire wr_mask    = wr_i && hit_mask;

  // A write to the flag mid-conversion is ignored and reported
  wire start_busy = start_flag_reg || (state_reg != ACS_IDLE);
  wire start_set  = wr_start && wdata_i[FLAG_BIT] && !start_busy;
  wire collide    = wr_start && start_busy;

  // Sequencer decode
  wire launch     = (state_reg == ACS_IDLE) && start_flag_reg;
  wire [CNT_W-1:0] len_sel = mode_reg[MODE_LEN_BIT] ? CONV_LONG : CONV_SHORT;
  wire [CNT_W-1:0] approx_at = len_reg - APPROX_LEAD;
  wire [CNT_W-1:0] last_at   = len_reg - LAST_LEAD;
  wire sample_end = (state_reg == ACS_SAMPLE) && tick && (cnt_reg == approx_at);
  wire approx_end = (state_reg == ACS_APPROX) && tick && (cnt_reg == last_at);
  wire store      = (state_reg == ACS_STORE);
  wire counting   = (state_reg == ACS_SAMPLE) || (state_reg == ACS_APPROX);

  // Events and interrupt; set wins over a write-one clear
  wire [EV_W-1:0] events;
  assign events[EV_DONE]    = store;
  assign events[EV_COLLIDE] = collide;
  wire [EV_W-1:0] stat_clr  = wr_stat ? wdata_i[EV_W-1:0] : IRQ_RST;
  wire [EV_W-1:0] stat_next = (stat_reg & ~stat_clr) | events;

  // Ladder current cut by flag or by any low-power mode
  wire ladder_next = !curoff_reg && !lowpower_i;

  // Read mux; write-only and unmapped addresses read zero
  wire [DATA_W-1:0] rd_mux =
    hit_res_lo ? result_reg[DATA_W-1:0] :
    hit_res_hi ? result_reg[RES_W-1:DATA_W] :
    hit_start  ? DATA_W'({start_flag_reg, 2'h0}) :
    hit_curoff ? DATA_W'({curoff_reg, 2'h0}) :
    hit_stat   ? DATA_W'(stat_reg) :
    hit_mask   ? DATA_W'(mask_reg) : 4'h0;

  // SAR handshake
  assign sar_bus.clear = launch;
  assign sar_bus.step  = (state_reg == ACS_APPROX) && tick;
  assign sar_bus.cmp   = cmp_sync_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACS_IDLE: begin
        if (launch) begin
          state_next = ACS_SAMPLE;
        end
      end
      ACS_SAMPLE: begin
        if (sample_end) begin
          state_next = ACS_APPROX;
        end
      end
      ACS_APPROX: begin
        if (approx_end) begin
          state_next = ACS_STORE;
        end
      end
      ACS_STORE: begin
        state_next = ACS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_i;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // Mode register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= wdata_i;
    end
  end

  // Start flag: software sets, hardware clears after the store
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      start_flag_reg <= 1'b0;
    end else if (start_set) begin
      start_flag_reg <= 1'b1;
    end else if (store) begin
      start_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      curoff_reg <= 1'b0;
    end else if (wr_curoff) begin
      curoff_reg <= wdata_i[FLAG_BIT];
    end
  end

  // Sequencer; a halted tick freezes the count in low power
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= ACS_IDLE;
      cnt_reg   <= '0;
      len_reg   <= CONV_SHORT;
      chan_reg  <= '0;
    end else begin
      state_reg <= state_next;
      if (launch) begin
        cnt_reg  <= '0;
        len_reg  <= len_sel;
        chan_reg <= mode_reg[MODE_CH_LSB +: CH_W];
      end else if (counting && tick) begin
        cnt_reg <= cnt_reg + CNT_STEP;
      end
    end
  end

  // No reset: the last result survives a reset
  always_ff @(posedge sys_clk_i) begin
    if (store) begin
      result_reg <= sar_bus.code;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat_reg   <= IRQ_RST;
      mask_reg   <= IRQ_RST;
      irq_reg    <= 1'b0;
      rdata_reg  <= '0;
      ladder_reg <= 1'b0;
      sample_reg <= 1'b0;
    end else begin
      stat_reg   <= stat_next;
      if (wr_mask) begin
        mask_reg <= wdata_i[EV_W-1:0];
      end
      irq_reg    <= |(stat_reg & mask_reg);
      rdata_reg  <= rd_i ? rd_mux : 4'h0;
      ladder_reg <= ladder_next;
      sample_reg <= (state_next == ACS_SAMPLE);
    end
  end

  assign rdata_o     = rdata_reg;
  assign chan_sel_o  = chan_reg;
  assign dac_code_o  = sar_bus.code;
  assign sample_o    = sample_reg;
  assign ladder_en_o = ladder_reg;
  assign busy_o      = start_flag_reg;
  assign irq_o       = irq_reg;

  // Helper: instruction ticks seen since launch
  logic [CNT_W-1:0] tick_seen_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || launch) begin
      tick_seen_reg <= '0;
    end else if (counting && tick) begin
      tick_seen_reg <= tick_seen_reg + CNT_STEP;
    end
  end

  // Helper: decisions made in this conversion
  logic [3:0] steps_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || launch) begin
      steps_reg <= 4'h0;
    end else if (sar_bus.step) begin
      steps_reg <= steps_reg + 4'h1;
    end
  end

  default clocking acs_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  conv_length_a: assert property (
    store |-> (tick_seen_reg == len_reg))
    else $error("Conversion did not last the selected tick count");

  length_select_a: assert property (
    launch |=> (len_reg == (mode_reg[MODE_LEN_BIT] ? CONV_LONG : CONV_SHORT)))
    else $error("Conversion length not taken from mode bit 0");

  chan_select_a: assert property (
    launch |=> (chan_sel_o == $past(mode_reg[MODE_CH_LSB +: CH_W])))
    else $error("Channel select does not follow mode bits 1 to 3");

  mode_reset_a: assert property (
    $fell(rst_i) |-> (mode_reg == MODE_RST))
    else $error("Mode register not zero after reset");

  eight_steps_a: assert property (
    store |-> (steps_reg == 4'h8))
    else $error("Result not built from eight decisions");

  result_load_a: assert property (
    store |=> (result_reg == $past(sar_bus.code)) && !start_flag_reg)
    else $error("Result not stored or start flag not cleared");

  result_hold_a: assert property (
    (state_reg != ACS_STORE) |=> $stable(result_reg))
    else $error("Result changed outside the store cycle");

  start_begin_a: assert property (
    start_set |=> start_flag_reg ##1 (state_reg == ACS_SAMPLE))
    else $error("Start flag write did not begin a conversion");

  read_digits_a: assert property (
    (rd_i && hit_res_hi) |=> (rdata_o == result_reg[RES_W-1:DATA_W]))
    else $error("Upper result digit read wrong");

  ladder_off_a: assert property (
    (curoff_reg || lowpower_i) |=> !ladder_en_o)
    else $error("Ladder current not cut");

  lowpower_freeze_a: assert property (
    lowpower_i |=> $stable(cnt_reg) && $stable(dac_code_o) || $past(launch))
    else $error("Conversion advanced in a low-power mode");

  irq_level_a: assert property (
    (|(stat_reg & mask_reg)) |=> irq_o)
    else $error("Unmasked status did not raise the interrupt");

  irq_low_a: assert property (
    !(|(stat_reg & mask_reg)) |=> !irq_o)
    else $error("Interrupt high with no unmasked status");

  status_clear_a: assert property (
    (wr_stat && !store) |=> ((stat_reg & $past(wdata_i[EV_W-1:0])) == IRQ_RST))
    else $error("Write-one clear left a status bit set");

  rdata_idle_a: assert property (
    !rd_i |=> (rdata_o == 4'h0))
    else $error("Read data not zero outside the answer cycle");

  low_digit_a: assert property (
    (rd_i && hit_res_lo) |=> (rdata_o == $past(result_reg[DATA_W-1:0])))
    else $error("Lower result digit read wrong");

  mode_write_a: assert property (
    wr_mode |=> (mode_reg == $past(wdata_i)))
    else $error("Mode register write not taken");

  sample_phase_a: assert property (
    sample_o == (state_reg == ACS_SAMPLE))
    else $error("Sample output does not match the sample phase");

  done_flag_a: assert property (
    store |=> stat_reg[EV_DONE])
    else $error("Done status not set after the store");

  collide_flag_a: assert property (
    collide |=> stat_reg[EV_COLLIDE])
    else $error("Refused start write not reported");

  conv_setup_hold_a: assert property (
    (state_reg != ACS_IDLE) |=> $stable(chan_sel_o) && $stable(len_reg))
    else $error("Channel or length changed during a conversion");

  ladder_on_a: assert property (
    (!curoff_reg && !lowpower_i) |=> ladder_en_o)
    else $error("Ladder current cut with flag clear in active mode");
endmodule // acs_seq_ctrl
`default_nettype wire

// File: dv/acs_seq_ctrl_tb.sv
// Purpose: Self-checking bench for the converter sequence control.
// Assumes: Ideal comparator against the trial code; no result read during a conversion.
// Notes: Lengths are checked with a small tolerance for instruction-tick phase.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import acs_pkg::*;
;
  logic              sys_clk_i  = 1'b0;
  logic              rst_i      = 1'b1;
  logic [ADDR_W-1:0] addr_i     = 8'h00;
  logic [DATA_W-1:0] wdata_i    = 4'h0;
  logic              wr_i       = 1'b0;
  logic              rd_i       = 1'b0;
  logic              lowpower_i = 1'b0;
  logic [RES_W-1:0]  analog_val = 8'h00;
  logic              cmp_i;
  logic [DATA_W-1:0] rdata_o;
  logic [CH_W-1:0]   chan_sel_o;
  logic [RES_W-1:0]  dac_code_o;
  logic              sample_o;
  logic              ladder_en_o;
  logic              busy_o;
  logic              irq_o;
  int                num_errors  = 0;
  int                check_count = 0;
  logic [3:0]        rd_val;
  logic [7:0]        vals [8] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'hfe, 8'h55, 8'haa};

  always #25 sys_clk_i = ~sys_clk_i;

  // Ideal analog comparator; settles well inside one instruction tick
  // Pin driven clean, no pull-up left holding it high
  assign cmp_i = (analog_val >= dac_code_o);

  acs_seq_ctrl dut (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .cmp_i       (cmp_i),
    .lowpower_i  (lowpower_i),
    .chan_sel_o  (chan_sel_o),
    .dac_code_o  (dac_code_o),
    .sample_o    (sample_o),
    .ladder_en_o (ladder_en_o),
    .busy_o      (busy_o),
    .irq_o       (irq_o)
  );

  task automatic summarize();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int exp);
    check_count++;
    if (n < exp - 4 || n > exp + 8) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, n, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [3:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Result is read only after the flag drops, never mid-conversion
  task automatic run_conv(input logic set_mode, input logic [2:0] ch, input logic len,
                          input logic [7:0] val, input int exp_n);
    int         n;
    logic [3:0] lo;
    logic [3:0] hi;
    n = 0;
    analog_val <= val;
    if (set_mode) reg_wr(MODE_OFS, {ch, len});
    reg_wr(START_OFS, 4'h4);
    #1;
    chk({7'h00, busy_o}, 8'h01);
    while (busy_o === 1'b1 && n < 1000) begin
      if (n == 4) chk({5'h00, chan_sel_o}, {5'h00, ch});
      if (n == 4) chk({7'h00, sample_o}, 8'h01);
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk_rng(n, exp_n);
    chk({7'h00, sample_o}, 8'h00);
    reg_rd(RES_LO_OFS, lo);
    reg_rd(RES_HI_OFS, hi);
    chk({hi, lo}, val);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    summarize();
  end

  initial begin
    cycles(20);
    rst_i <= 1'b0;
    cycles(2);
    #1;
    chk({7'h00, ladder_en_o}, 8'h01);
    chk({6'h00, busy_o, irq_o}, 8'h00);
    reg_rd(MODE_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h00);
    reg_rd(8'h40, rd_val);
    chk({4'h0, rd_val}, 8'h00);
    reg_rd(START_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h00);
    // Every channel, both lengths, boundary codes
    for (int c = 0; c < 8; c++) begin
      run_conv(1'b1, c[2:0], c[0], vals[c], c[0] ? 67 * 4 : 34 * 4);
    end
    // Held value survives a changed input
    analog_val <= 8'h11;
    cycles(50);
    reg_rd(RES_LO_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h0a);
    reg_rd(RES_HI_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h0a);
    // Done event is sticky but masked
    chk({7'h00, irq_o}, 8'h00);
    reg_rd(IRQ_STAT_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h01);
    reg_wr(IRQ_MASK_OFS, 4'h1);
    cycles(3);
    chk({7'h00, irq_o}, 8'h01);
    reg_wr(IRQ_STAT_OFS, 4'h1);
    cycles(3);
    chk({7'h00, irq_o}, 8'h00);
    reg_rd(IRQ_STAT_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h00);
    // Start write during a conversion is refused and flagged
    fork
      begin
        cycles(20);
        reg_rd(START_OFS, rd_val);
        chk({4'h0, rd_val}, 8'h04);
        reg_wr(START_OFS, 4'h4);
        reg_rd(IRQ_STAT_OFS, rd_val);
        chk({4'h0, rd_val}, 8'h02);
      end
    join_none
    run_conv(1'b1, 3'h5, 1'b0, 8'h9c, 34 * 4);
    reg_rd(IRQ_STAT_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h03);
    reg_wr(IRQ_MASK_OFS, 4'h2);
    cycles(3);
    chk({7'h00, irq_o}, 8'h01);
    reg_wr(IRQ_STAT_OFS, 4'h3);
    cycles(3);
    chk({7'h00, irq_o}, 8'h00);
    // Current-off flag
    reg_wr(CUROFF_OFS, 4'h4);
    cycles(2);
    chk({7'h00, ladder_en_o}, 8'h00);
    reg_rd(CUROFF_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h04);
    reg_wr(CUROFF_OFS, 4'h0);
    cycles(2);
    chk({7'h00, ladder_en_o}, 8'h01);
    // Low power in mid-conversion freezes it and cuts the ladder
    fork
      begin : lp_proc
        logic [7:0] d0;
        // Late enough that some decisions are already made
        cycles(116);
        lowpower_i <= 1'b1;
        cycles(3);
        #1;
        d0 = dac_code_o;
        chk({7'h00, ladder_en_o}, 8'h00);
        cycles(300);
        lowpower_i <= 1'b0;
        #1;
        chk(dac_code_o, d0);
        chk({7'h00, busy_o}, 8'h01);
      end
    join_none
    run_conv(1'b1, 3'h2, 1'b0, 8'h6b, 34 * 4 + 303);
    // Reset keeps the result, clears the mode
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    cycles(20);
    rst_i <= 1'b0;
    cycles(2);
    #1;
    chk({6'h00, busy_o, irq_o}, 8'h00);
    reg_rd(RES_LO_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h0b);
    reg_rd(RES_HI_OFS, rd_val);
    chk({4'h0, rd_val}, 8'h06);
    run_conv(1'b0, 3'h0, 1'b0, 8'h3c, 34 * 4);
    summarize();
  end
endmodule // testbench
`default_nettype wire
